// [ssc_defs.svh]
// Register offsets, field positions, reset values and codes of the safe state controller
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH

// Register byte offsets
`define SSC_OFS_CTRL 8'h00
`define SSC_OFS_STATUS 8'h04
`define SSC_OFS_SENS_SAFE 8'h08
`define SSC_OFS_SENS_VAL 8'h0c
`define SSC_OFS_VALVE_SAFE 8'h10
`define SSC_OFS_VALVE_VAL 8'h14
`define SSC_OFS_VALVE_OVR 8'h18
`define SSC_OFS_CTRL_SAFE 8'h1c
`define SSC_OFS_DTYPE 8'h20
`define SSC_OFS_APP_SEL 8'h24
`define SSC_OFS_CAL 8'h28
`define SSC_OFS_PRESS 8'h2c
`define SSC_OFS_VALVE 8'h30

// Control register bits
`define SSC_CTRL_RUN_BIT 0
`define SSC_CTRL_STOP_BIT 1

// Data type field positions
`define SSC_DT_P_LSB 0
`define SSC_DT_V_LSB 8
`define SSC_DT_C_LSB 16

// Data type codes
`define SSC_DT_INT 8'h01
`define SSC_DT_REAL 8'h02
`define SSC_DT_INFER 8'h01

// Sensor safe codes
`define SSC_SS_ZERO 8'h00
`define SSC_SS_FULL 8'h01
`define SSC_SS_HOLD 8'h02
`define SSC_SS_SAFEVAL 8'h03
`define SSC_SS_CONT 8'h04
`define SSC_SS_TRACK 8'h64

// Valve safe codes
`define SSC_VS_CLOSED 2'h0
`define SSC_VS_OPEN 2'h1
`define SSC_VS_HOLD 2'h2
`define SSC_VS_SAFEVAL 2'h3

// Valve override codes
`define SSC_OV_NORMAL 3'h0
`define SSC_OV_CLOSED 3'h1
`define SSC_OV_OPEN 3'h2
`define SSC_OV_HOLD 3'h3
`define SSC_OV_SAFE 3'h4

// Reset values and defaults
`define SSC_RST_SENS_SAFE 8'h00
`define SSC_RST_VALVE_SAFE 2'h0
`define SSC_RST_OVR 3'h0
`define SSC_RST_CTRL_SAFE 8'h00
`define SSC_RST_APP 8'h01
`define SSC_FULL_SCALE 16'h6000
`define SSC_NUM_CAL 4
`define SSC_CAL_UNITY 16'h1000
`define SSC_CAL_SHIFT 12

`endif

// [ssc_pkg.sv]
// Types of the safe state controller
package ssc_pkg;

  // Operational state, one-hot
  typedef enum logic [2:0] {
    SSC_IDLE = 3'b001,
    SSC_EXEC = 3'b010,
    SSC_FAULT = 3'b100
  } ssc_state_t;

  // Link events from the fieldbus side
  typedef struct packed {
    logic conn_active;
    logic data_rx;
    logic timeout;
    logic fault;
  } ssc_link_t;

  // Whole state of the top module
  typedef struct packed {
    logic [1:0] conn_s;
    logic [1:0] rx_s;
    logic [1:0] to_s;
    logic [1:0] flt_s;
    logic rx_h;
    logic to_h;
    ssc_state_t st;
    logic rdy;
    logic [31:0] rdata;
    logic err;
    logic [7:0] sens_safe;
    logic [15:0] sens_val;
    logic [1:0] valve_safe;
    logic [15:0] valve_val;
    logic [2:0] ovr;
    logic ovr_on;
    logic [7:0] ctrl_safe;
    logic [7:0] dt_p;
    logic [7:0] dt_v;
    logic [7:0] dt_c;
    logic [7:0] app;
    logic [15:0] press;
    logic [15:0] valve;
    logic [15:0] setp;
    logic [15:0] hold_p;
    logic [15:0] hold_v;
    logic [15:0] ovr_hold;
    logic exec;
    logic safe;
    logic io_seen;
  } ssc_regs_t;

endpackage

// [ssc_cal_mem.sv]
// Calibration gain memory, one word per pressure application
`timescale 1ns/1ps
`default_nettype none

module ssc_cal_mem #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write side
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read side
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data_q
);

  // Memory words and registered read port
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rd;
  } ssc_mem_st_t;

  ssc_mem_st_t q, d;

  // Next state: write then registered read
  always_comb begin
    d = q;
    if (wr_en) begin
      d.mem[wr_addr] = wr_data;
    end
    // Old data on a same-cycle write, new data one cycle later
    d.rd = q.mem[rd_addr];
  end

  // Every entry starts at unity so an unwritten set is harmless
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= {(DEPTH + 1){INIT}};
    end else begin
      q <= d;
    end
  end

  assign rd_data_q = q.rd;

endmodule

`default_nettype wire

// [ssc_top.sv]
// Safe state controller: operational state, safe mode outputs and APB settings
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defs.svh"

module ssc_top #(
  parameter int NUM_CAL = `SSC_NUM_CAL,
  parameter logic [15:0] FULL_SCALE = `SSC_FULL_SCALE
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Fieldbus link events, asynchronous
  input wire ssc_pkg::ssc_link_t link,
  // Process values, same clock
  input wire logic [15:0] raw_pressure,
  input wire logic [15:0] ctrl_valve,
  input wire logic [15:0] setpoint,
  // Process outputs
  output logic [15:0] pressure,
  output logic [15:0] valve,
  output logic [15:0] setpoint_used,
  output logic ctrl_run,
  output logic safe_mode,
  output logic executing,
  output logic [7:0] dtype_pressure,
  output logic [7:0] dtype_valve,
  output logic [7:0] dtype_ctrl
);

  localparam int AW = $clog2(NUM_CAL);
  // Register and next state
  ssc_pkg::ssc_regs_t q, d;
  // Bus decode, calibration and link event helpers
  logic wr_done;
  logic [15:0] cal_gain;
  logic [31:0] lin_prod;
  logic [15:0] lin;
  logic rx_rise;
  logic to_rise;
  logic run_req;
  logic stop_req;
  logic dt_ok;
  // Sensor safe code is one of the listed values
  function automatic logic sens_code_ok(input logic [7:0] c);
    return c inside {`SSC_SS_ZERO, `SSC_SS_FULL, `SSC_SS_HOLD, `SSC_SS_SAFEVAL,
                     `SSC_SS_CONT, `SSC_SS_TRACK};
  endfunction
  // Accepted codes for the pressure data type
  function automatic logic dtype_ok(input logic [7:0] c);
    return (c == `SSC_DT_INT) || (c == `SSC_DT_REAL);
  endfunction
  // Valve position for a safe-state code, same for either valve type
  function automatic logic [15:0] valve_safe_pos(input logic [1:0] c,
      input logic [15:0] hold, input logic [15:0] sval, input logic [15:0] fs);
    unique case (c)
      `SSC_VS_CLOSED: return 16'h0000;
      `SSC_VS_OPEN: return fs;
      `SSC_VS_HOLD: return hold;
      default: return sval;
    endcase
  endfunction
  // Calibration sets indexed by application minus one
  ssc_cal_mem #(
    .DEPTH(NUM_CAL),
    .WIDTH(16),
    .INIT(`SSC_CAL_UNITY)
  ) u_cal (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_done && pwrite && (paddr == `SSC_OFS_CAL)),
    .wr_addr(AW'(q.app - 8'h01)),
    .wr_data(pwdata[15:0]),
    .rd_addr(AW'(q.app - 8'h01)),
    .rd_data_q(cal_gain)
  );
  // Linearised reading from the selected calibration
  assign lin_prod = raw_pressure * cal_gain;
  assign lin = lin_prod[`SSC_CAL_SHIFT +: 16];
  // Event decode on second synchroniser stage only
  assign rx_rise = q.rx_s[1] && !q.rx_h;
  assign to_rise = q.to_s[1] && !q.to_h;
  assign wr_done = psel && penable && q.rdy && !q.err;
  assign run_req = wr_done && pwrite && (paddr == `SSC_OFS_CTRL) &&
                   pwdata[`SSC_CTRL_RUN_BIT];
  assign stop_req = wr_done && pwrite && (paddr == `SSC_OFS_CTRL) &&
                    pwdata[`SSC_CTRL_STOP_BIT];
  assign dt_ok = dtype_ok(pwdata[`SSC_DT_P_LSB +: 8]);
  // Next state of the whole block
  always_comb begin
    d = q;
    // Two-stage synchronisers and edge history
    d.conn_s = {q.conn_s[0], link.conn_active};
    d.rx_s = {q.rx_s[0], link.data_rx};
    d.to_s = {q.to_s[0], link.timeout};
    d.flt_s = {q.flt_s[0], link.fault};
    d.rx_h = q.rx_s[1];
    d.to_h = q.to_s[1];
    // Operational state machine
    unique case (q.st)
      ssc_pkg::SSC_IDLE: begin
        if (q.flt_s[1]) begin
          d.st = ssc_pkg::SSC_FAULT;
        end else if (q.conn_s[1] && rx_rise) begin
          d.st = ssc_pkg::SSC_EXEC;
          // Inferred type of the assembly overrides the settings
          d.dt_p = `SSC_DT_INFER;
          d.dt_v = `SSC_DT_INFER;
          d.dt_c = `SSC_DT_INFER;
          d.io_seen = 1'b1;
        end else if (run_req) begin
          d.st = ssc_pkg::SSC_EXEC;
        end
      end
      ssc_pkg::SSC_EXEC: begin
        if (q.flt_s[1]) begin
          d.st = ssc_pkg::SSC_FAULT;
        end else if (to_rise || stop_req || (!q.conn_s[1] && q.io_seen)) begin
          // A directive-run with no link open stays until stopped, timed out or faulted
          d.st = ssc_pkg::SSC_IDLE;
        end
      end
      ssc_pkg::SSC_FAULT: begin
        // Fault clears back to idle, never straight to execute
        if (!q.flt_s[1]) begin
          d.st = ssc_pkg::SSC_IDLE;
        end
      end
      default: begin
        d.st = ssc_pkg::SSC_IDLE;
      end
    endcase
    d.exec = (d.st == ssc_pkg::SSC_EXEC);
    d.safe = !d.exec;
    d.io_seen = d.io_seen && d.exec;
    // Hold registers caught on the exit cycle
    if (q.st == ssc_pkg::SSC_EXEC && d.st != ssc_pkg::SSC_EXEC) begin
      d.hold_p = q.press;
      d.hold_v = q.valve;
    end
    // Override hold value caught when an override is first applied
    d.ovr_on = q.exec && (q.ovr != `SSC_OV_NORMAL);
    if (d.ovr_on && !q.ovr_on) begin
      d.ovr_hold = q.valve;
    end
    // Reported pressure
    if (q.exec) begin
      d.press = lin;
    end else begin
      unique case (q.sens_safe)
        `SSC_SS_FULL: d.press = FULL_SCALE;
        `SSC_SS_HOLD: d.press = q.hold_p;
        `SSC_SS_SAFEVAL: d.press = q.sens_val;
        `SSC_SS_CONT, `SSC_SS_TRACK: d.press = lin;
        default: d.press = 16'h0000;
      endcase
    end
    // Valve command; safe mode ignores the override entirely
    if (!q.exec) begin
      d.valve = valve_safe_pos(q.valve_safe, q.hold_v, q.valve_val,
                               FULL_SCALE);
    end else begin
      unique case (q.ovr)
        `SSC_OV_CLOSED: d.valve = 16'h0000;
        `SSC_OV_OPEN: d.valve = FULL_SCALE;
        `SSC_OV_HOLD: d.valve = q.ovr_on ? q.ovr_hold : q.valve;
        `SSC_OV_SAFE: d.valve = valve_safe_pos(q.valve_safe, q.valve,
                                               q.valve_val, FULL_SCALE);
        default: d.valve = ctrl_valve;
      endcase
    end
    // Setpoint passes only while executing; controller safe code 0 zeroes it
    if (q.exec) begin
      d.setp = setpoint;
    end else if (q.ctrl_safe == `SSC_RST_CTRL_SAFE) begin
      d.setp = 16'h0000;
    end
    // APB: pready rises one cycle into the access phase
    d.rdy = psel && penable && !q.rdy;
    // Refusal flag lives only beside pready, so the pin needs no gate
    d.err = 1'b0;
    if (psel && penable && !q.rdy) begin
      d.rdata = 32'h0000_0000;
      unique case (paddr)
        `SSC_OFS_CTRL: d.rdata = 32'h0000_0000;
        `SSC_OFS_STATUS: d.rdata = {29'h0, q.st == ssc_pkg::SSC_FAULT, q.safe, q.exec};
        `SSC_OFS_SENS_SAFE: begin
          d.rdata = {24'h0, q.sens_safe};
          d.err = pwrite && !sens_code_ok(pwdata[7:0]);
        end
        `SSC_OFS_SENS_VAL: d.rdata = {16'h0, q.sens_val};
        `SSC_OFS_VALVE_SAFE: d.rdata = {30'h0, q.valve_safe};
        `SSC_OFS_VALVE_VAL: d.rdata = {16'h0, q.valve_val};
        `SSC_OFS_VALVE_OVR: begin
          d.rdata = {29'h0, q.ovr};
          d.err = pwrite && (pwdata[2:0] > `SSC_OV_SAFE);
        end
        `SSC_OFS_CTRL_SAFE: d.rdata = {24'h0, q.ctrl_safe};
        `SSC_OFS_DTYPE: begin
          d.rdata = {8'h0, q.dt_c, q.dt_v, q.dt_p};
          // Locked while polled or executing; bad pressure type code refused
          d.err = pwrite && (!dt_ok || q.st != ssc_pkg::SSC_IDLE ||
                             q.conn_s[1]);
        end
        `SSC_OFS_APP_SEL: begin
          d.rdata = {24'h0, q.app};
          d.err = pwrite && ((pwdata[7:0] == 8'h00) ||
                             (pwdata[7:0] > 8'(NUM_CAL)));
        end
        `SSC_OFS_CAL: d.rdata = {16'h0, cal_gain};
        `SSC_OFS_PRESS: d.rdata = {16'h0, q.press};
        `SSC_OFS_VALVE: d.rdata = {16'h0, q.valve};
        default: d.err = 1'b1;
      endcase
    end
    // Register writes at the completing edge only
    if (wr_done && pwrite) begin
      unique case (paddr)
        `SSC_OFS_SENS_SAFE: d.sens_safe = pwdata[7:0];
        `SSC_OFS_SENS_VAL: d.sens_val = pwdata[15:0];
        `SSC_OFS_VALVE_SAFE: d.valve_safe = pwdata[1:0];
        `SSC_OFS_VALVE_VAL: d.valve_val = pwdata[15:0];
        `SSC_OFS_VALVE_OVR: d.ovr = pwdata[2:0];
        `SSC_OFS_CTRL_SAFE: d.ctrl_safe = pwdata[7:0];
        `SSC_OFS_DTYPE: begin
          d.dt_p = pwdata[`SSC_DT_P_LSB +: 8];
          d.dt_v = pwdata[`SSC_DT_V_LSB +: 8];
          d.dt_c = pwdata[`SSC_DT_C_LSB +: 8];
        end
        `SSC_OFS_APP_SEL: d.app = pwdata[7:0];
        default: d.app = q.app;
      endcase
    end
  end

  // Registered state; reset leaves the block idle with defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= ssc_pkg::SSC_IDLE;
      q.safe <= 1'b1;
      q.sens_safe <= `SSC_RST_SENS_SAFE;
      q.valve_safe <= `SSC_RST_VALVE_SAFE;
      q.ovr <= `SSC_RST_OVR;
      q.ctrl_safe <= `SSC_RST_CTRL_SAFE;
      q.dt_p <= `SSC_DT_INT;
      q.dt_v <= `SSC_DT_INT;
      q.dt_c <= `SSC_DT_INT;
      q.app <= `SSC_RST_APP;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign pready = q.rdy;
  assign prdata = q.rdata;
  assign pslverr = q.err;
  assign pressure = q.press;
  assign valve = q.valve;
  assign setpoint_used = q.setp;
  assign ctrl_run = q.exec;
  assign safe_mode = q.safe;
  assign executing = q.exec;
  assign dtype_pressure = q.dt_p;
  assign dtype_valve = q.dt_v;
  assign dtype_ctrl = q.dt_c;

  // Two settled safe cycles in a row
  sequence s_safe_steady;
    !q.exec ##1 !q.exec;
  endsequence

  a_safe_mode_flag: assert property (@(posedge pclk) disable iff (!presetn)
    q.safe == (q.st != ssc_pkg::SSC_EXEC)) else $error("safe flag wrong");
  a_fault_exits: assert property (@(posedge pclk) disable iff (!presetn)
    q.exec && q.flt_s[1] |=> !q.exec ##1 !q.exec) else $error("fault kept exec");
  a_timeout_exit: assert property (@(posedge pclk) disable iff (!presetn)
    q.exec && to_rise |=> !q.exec) else $error("timeout kept exec");
  a_run_enters: assert property (@(posedge pclk) disable iff (!presetn)
    q.st == ssc_pkg::SSC_IDLE && run_req && !q.flt_s[1] |=> q.exec)
    else $error("run not taken");
  a_infer_dtype: assert property (@(posedge pclk) disable iff (!presetn)
    q.st == ssc_pkg::SSC_IDLE && !q.flt_s[1] && q.conn_s[1] && rx_rise
    |=> q.exec && q.dt_p == `SSC_DT_INFER) else $error("type not forced");
  a_valve_closed: assert property (@(posedge pclk) disable iff (!presetn)
    s_safe_steady ##0 ($stable(q.valve_safe) && q.valve_safe == `SSC_VS_CLOSED)
    |=> q.valve == 16'h0000) else $error("valve not closed");
  a_sens_full: assert property (@(posedge pclk) disable iff (!presetn)
    !q.exec && q.sens_safe == `SSC_SS_FULL |=> q.press == FULL_SCALE)
    else $error("not full scale");
  a_sens_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !q.exec && q.sens_safe == `SSC_SS_HOLD |=> q.press == $past(q.hold_p))
    else $error("hold lost");
  a_hold_capture: assert property (@(posedge pclk) disable iff (!presetn)
    q.exec ##1 !q.exec |-> q.hold_p == $past(q.press)) else $error("no capture");
  a_dtype_lock: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && pwrite && paddr == `SSC_OFS_DTYPE |-> q.st == ssc_pkg::SSC_IDLE && dt_ok)
    else $error("type write taken");
  a_app_range: assert property (@(posedge pclk) disable iff (!presetn)
    q.app >= 8'h01 && q.app <= 8'(NUM_CAL)) else $error("app out of range");

endmodule

`default_nettype wire

// [ssc_link_model.sv]
// Fieldbus master model: connection, data, timeout and fault events
`timescale 1ns/1ps
`default_nettype none

module ssc_link_model (
  // Clock
  input wire logic pclk,
  // Link events towards the device
  output var ssc_pkg::ssc_link_t link
);
  // Link quiet at time zero
  initial begin
    link = '0;
  end

  // Open or close the I/O connection
  task automatic set_conn(input logic v);
    @(posedge pclk);
    link.conn_active <= v;
  endtask

  // Severe fault level inside the device
  task automatic set_fault(input logic v);
    @(posedge pclk);
    link.fault <= v;
  endtask

  // One non-empty data exchange, held long enough to cross the synchroniser
  task automatic pulse_rx();
    @(posedge pclk);
    link.data_rx <= 1'b1;
    repeat (4) @(posedge pclk);
    link.data_rx <= 1'b0;
  endtask

  // Expected packet interval ran out
  task automatic pulse_to();
    @(posedge pclk);
    link.timeout <= 1'b1;
    repeat (4) @(posedge pclk);
    link.timeout <= 1'b0;
  endtask
endmodule

`default_nettype wire

// [ssc_top_tb.sv]
// Self-checking testbench of the safe state controller
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defs.svh"

module ssc_top_tb;
  localparam int NC = 4; // Installed calibrations
  localparam logic [15:0] FS = 16'h6000; // Full scale counts
  // Safe mode table row: codes and the outputs they give in idle
  typedef struct packed {
    logic [7:0] ss;
    logic [1:0] vs;
    logic [15:0] r;
    logic [15:0] p;
    logic [15:0] v;
  } ssc_row_t;

  // Clock, reset and APB
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  // Process side
  ssc_pkg::ssc_link_t link;
  logic [15:0] raw_pressure, ctrl_valve, setpoint, pressure, valve, setpoint_used;
  logic ctrl_run, safe_mode, executing;
  logic [7:0] dtype_pressure, dtype_valve, dtype_ctrl;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  ssc_row_t rows [5];

  ssc_top #(.NUM_CAL(NC), .FULL_SCALE(FS)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .link(link), .raw_pressure(raw_pressure), .ctrl_valve(ctrl_valve),
    .setpoint(setpoint), .pressure(pressure), .valve(valve),
    .setpoint_used(setpoint_used), .ctrl_run(ctrl_run), .safe_mode(safe_mode),
    .executing(executing), .dtype_pressure(dtype_pressure), .dtype_valve(dtype_valve),
    .dtype_ctrl(dtype_ctrl));

  ssc_link_model u_link (.pclk(pclk), .link(link));

  // Clock, 40 ns period
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Cut a hang short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end

  // Verdict and end of run
  task automatic test_done();
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One comparison, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
      n_errors++;
    end
  endtask

  // One APB transfer; waits for pready, never assumes its latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(0, 1, "no pready");
  endtask

  // Write and check the refusal flag
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    logic [31:0] r;
    logic g;
    apb(1'b1, a, d, r, g);
    chk(g, e, "slave error on write");
  endtask

  // Read and check the data
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic g;
    apb(1'b0, a, 32'h0, r, g);
    chk(r, x, "read data");
  endtask

  // Wait, bounded, for the operating state, then let the outputs follow
  task automatic wait_exec(input logic v);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (executing !== v && n < 20);
    repeat (2) @(posedge pclk);
    chk(executing, v, "executing");
    chk(safe_mode, !v, "safe mode");
    chk(ctrl_run, v, "control running");
  endtask

  // Settle three cycles, then compare; a new gain needs the extra one
  task automatic pv(input logic [15:0] p, input logic [15:0] v);
    repeat (3) @(posedge pclk);
    chk(pressure, p, "pressure");
    chk(valve, v, "valve");
  endtask

  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
    raw_pressure = 16'h1234; ctrl_valve = 16'h2222; setpoint = 16'h0555;
    presetn = 1'b0;
    rows = '{'{8'h00, 2'h0, 16'h1234, 16'h0000, 16'h0000},
             '{8'h01, 2'h1, 16'h1234, FS, FS},
             '{8'h03, 2'h3, 16'h1234, 16'h0aaa, 16'h0bbb},
             '{8'h04, 2'h0, 16'h0800, 16'h0800, 16'h0000},
             '{8'h64, 2'h1, 16'h1234, 16'h1234, FS}};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Reset state and defaults
    pv(16'h0000, 16'h0000);
    chk(executing, 1'b0, "reset exec");
    chk({dtype_ctrl, dtype_valve, dtype_pressure}, 24'h010101, "reset types");
    rd(`SSC_OFS_SENS_SAFE, 32'h0);
    rd(`SSC_OFS_VALVE_SAFE, 32'h0);
    rd(`SSC_OFS_VALVE_OVR, 32'h0);
    rd(`SSC_OFS_APP_SEL, 32'h1);
    // Safe values, then the sensor and valve safe codes from the table, all but the hold codes
    wr(`SSC_OFS_SENS_VAL, 32'h0aaa, 1'b0);
    wr(`SSC_OFS_VALVE_VAL, 32'h0bbb, 1'b0);
    foreach (rows[i]) begin
      raw_pressure <= rows[i].r;
      wr(`SSC_OFS_SENS_SAFE, {24'h0, rows[i].ss}, 1'b0);
      wr(`SSC_OFS_VALVE_SAFE, {30'h0, rows[i].vs}, 1'b0);
      pv(rows[i].p, rows[i].v);
    end
    // Refused settings, and one accepted data type write
    wr(`SSC_OFS_SENS_SAFE, 32'h05, 1'b1);
    wr(8'h40, 32'h1, 1'b1);
    rd(8'h40, 32'h0);
    wr(`SSC_OFS_VALVE_OVR, 32'h5, 1'b1);
    wr(`SSC_OFS_APP_SEL, 32'h0, 1'b1);
    wr(`SSC_OFS_APP_SEL, NC + 1, 1'b1);
    wr(`SSC_OFS_DTYPE, 32'h0003, 1'b1);
    wr(`SSC_OFS_DTYPE, 32'h020202, 1'b0);
    rd(`SSC_OFS_DTYPE, 32'h020202);
    // Application select picks its own gain
    wr(`SSC_OFS_APP_SEL, NC, 1'b0);
    wr(`SSC_OFS_CAL, 32'h2000, 1'b0);
    pv(16'h2468, FS);
    wr(`SSC_OFS_APP_SEL, 32'h1, 1'b0);
    rd(`SSC_OFS_CAL, 32'h1000);
    // I/O start: executing, inferred types, live outputs, types locked
    u_link.set_conn(1'b1);
    u_link.pulse_rx();
    wait_exec(1'b1);
    chk({dtype_ctrl, dtype_valve, dtype_pressure}, 24'h010101, "inferred");
    chk(setpoint_used, 16'h0555, "setpoint");
    pv(16'h1234, 16'h2222);
    wr(`SSC_OFS_DTYPE, 32'h000002, 1'b1);
    // Overrides while executing
    wr(`SSC_OFS_VALVE_OVR, 32'h1, 1'b0);
    pv(16'h1234, 16'h0000);
    wr(`SSC_OFS_VALVE_OVR, 32'h2, 1'b0);
    pv(16'h1234, FS);
    wr(`SSC_OFS_VALVE_OVR, 32'h4, 1'b0);
    pv(16'h1234, FS);
    wr(`SSC_OFS_VALVE_OVR, 32'h0, 1'b0);
    pv(16'h1234, 16'h2222);
    wr(`SSC_OFS_VALVE_OVR, 32'h3, 1'b0);
    ctrl_valve <= 16'h3333;
    pv(16'h1234, 16'h2222);
    wr(`SSC_OFS_VALVE_OVR, 32'h0, 1'b0);
    pv(16'h1234, 16'h3333);
    // Timeout with hold codes: frozen values, inputs ignored
    wr(`SSC_OFS_SENS_SAFE, 32'h02, 1'b0);
    wr(`SSC_OFS_VALVE_SAFE, 32'h2, 1'b0);
    u_link.pulse_to();
    wait_exec(1'b0);
    raw_pressure <= 16'h4444;
    ctrl_valve <= 16'h5555;
    setpoint <= 16'h0777;
    wr(`SSC_OFS_VALVE_OVR, 32'h1, 1'b0);
    pv(16'h1234, 16'h3333);
    chk(setpoint_used, 16'h0000, "safe setpoint");
    rd(`SSC_OFS_PRESS, 32'h1234);
    wr(`SSC_OFS_VALVE_OVR, 32'h0, 1'b0);
    u_link.set_conn(1'b0);
    // Run and stop directives, then a severe fault
    wr(`SSC_OFS_CTRL, 32'h1, 1'b0);
    wait_exec(1'b1);
    pv(16'h4444, 16'h5555);
    wr(`SSC_OFS_CTRL, 32'h2, 1'b0);
    wait_exec(1'b0);
    wr(`SSC_OFS_CTRL, 32'h1, 1'b0);
    wait_exec(1'b1);
    u_link.set_fault(1'b1);
    wait_exec(1'b0);
    u_link.set_fault(1'b0);
    // Closing the connection ends execution
    u_link.set_conn(1'b1);
    u_link.pulse_rx();
    wait_exec(1'b1);
    u_link.set_conn(1'b0);
    wait_exec(1'b0);
    // Second reset while idle restores defaults
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`SSC_OFS_SENS_SAFE, 32'h0);
    chk(executing, 1'b0, "reset exec");
    test_done();
  end
endmodule

`default_nettype wire
